// ==== spu_pkg.sv ====
// package for the pack/unpack/align datapath: opcodes, widths, carriers
package spu_pkg;

    localparam int SPU_VEC_W    = 128;          // wide register width
    localparam int SPU_NAR_W    = 64;           // narrow register width
    localparam int SPU_ADDR_W   = 64;           // memory address width
    localparam int SPU_WIDE_AL  = 16;           // wide alignment in bytes
    localparam int SPU_NAR_AL   = 8;            // narrow alignment in bytes
    localparam int SPU_LINE_B   = 64;           // cache line size in bytes
    localparam int SPU_SHAMT_W  = 6;            // shift count field width
    localparam int SPU_IMM_W    = 5;            // byte-align immediate width
    localparam logic [15:0] SPU_W_MAX = 16'h7FFF;   // signed word ceiling
    localparam logic [15:0] SPU_W_MIN = 16'h8000;   // signed word floor
    localparam logic [7:0]  SPU_B_MAX = 8'hFF;      // unsigned byte ceiling
    localparam logic [7:0]  SPU_B_MIN = 8'h00;      // unsigned byte floor
    localparam logic [5:0]  SPU_SRA_MAX = 6'h1F;    // largest useful dword shift

    // operation codes issued by decode
    typedef enum logic [3:0] {
        SPU_OP_NOP,
        SPU_OP_PACK_DW_W,     // signed dword to signed word, saturating
        SPU_OP_PACK_W_UB,     // pack_signed_word_to_unsigned_byte_sat
        SPU_OP_UNPK_LO_W,     // interleave low words
        SPU_OP_UNPK_HI_W,     // interleave high words
        SPU_OP_SRA_DW,        // packed_arith_shift_right_dword
        SPU_OP_ALIGN_B,       // byte align by immediate
        SPU_OP_LOAD,          // aligned vector memory reference
        SPU_OP_LOAD_U         // unaligned_wide_move
    } spu_op_type;

    // request from decode/issue
    typedef struct packed {
        logic                   valid;
        spu_op_type             op;
        logic                   wide;   // 1 = 128-bit form, 0 = 64-bit form
        logic [SPU_VEC_W-1:0]   dst;    // destination operand
        logic [SPU_VEC_W-1:0]   src;    // source operand
        logic [SPU_SHAMT_W-1:0] shamt;  // shift count
        logic [SPU_IMM_W-1:0]   imm;    // byte-align count
        logic [SPU_ADDR_W-1:0]  addr;   // memory reference address
    } spu_req_type;

    // result back to issue
    typedef struct packed {
        logic                 valid;
        logic [SPU_VEC_W-1:0] data;
        logic                 fault;      // alignment exception
        logic                 lineSplit;  // access spans two lines
    } spu_rsp_type;

endpackage : spu_pkg

// ==== spu_unit.sv ====
// packed-integer pack, unpack, shift, byte-align and alignment-check datapath
`timescale 1ns/1ns
// Functional notes
// - misaligned wide reference faults unless unaligned move
// - narrow aligned at 8 bytes, wide 16
// - misaligned narrow access completes, flags line split when it crosses a line
// - unpack with zero operand zero-extends words
// - low/high unpack interleave four low/high words (two in the narrow form)
// - arithmetic dword shift replicates sign bit
// - narrow dword pack: two plus two words
// - wide dword pack: four plus four words
// - pack sources always read as signed
// - dword pack clamps to signed word range
// - byte pack clamps words to unsigned bytes
// - low unpack starts with destination lowest word
module spu_unit
    import spu_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire spu_req_type req,
    output spu_rsp_type      rsp
);

    // overview: a purely combinational datapath feeds one output register.
    // every taken request produces exactly one result one cycle later, so
    // issue may present a new operation on every clock with no back-pressure.
    // the narrow (64-bit) forms read only the low halves of dst and src and
    // always return zeros in the upper half; issue need not clear the rest.
    // memory references only get their address checked here: the data
    // itself moves on a separate path, so their result word is zero.
    // trade-off: all arms share one result bus instead of per-op registers,
    // which costs a wide mux but keeps the output timing the same for all.

    ////////////////////////////////////////////////////////////////////////
    // element helpers
    // saturation helpers are shared by the wide and narrow pack forms

    // signed 32 to signed 16 clamp; top bits read as sign
    // the value fits only when bits 31..15 all agree with the sign bit;
    // any disagreement means overflow toward the sign's own extreme
    function automatic logic [15:0] satDw(input logic [31:0] v);
        if (!v[31] && (v[30:15] != 16'h0000)) begin
            satDw = SPU_W_MAX;
        end else if (v[31] && (v[30:15] != 16'hFFFF)) begin
            satDw = SPU_W_MIN;
        end else begin
            satDw = v[15:0];
        end
    endfunction : satDw

    // signed 16 to unsigned 8 clamp; negatives floor at zero
    // the word is always read as signed, so 0x8000 floors rather than
    // clamping high as an unsigned reading would suggest
    function automatic logic [7:0] satWb(input logic [15:0] v);
        if (v[15]) begin
            satWb = SPU_B_MIN;
        end else if (v[14:8] != 7'h00) begin
            satWb = SPU_B_MAX;
        end else begin
            satWb = v[7:0];
        end
    endfunction : satWb

    // misalignment test against a power-of-two boundary
    // only valid for power-of-two sizes; both callers pass 8 or 16
    // a non-power-of-two size would silently test the wrong low bits
    function automatic logic misaligned(input logic [SPU_ADDR_W-1:0] a,
                                        input int                    bytes);
        misaligned = (a & SPU_ADDR_W'(bytes - 1)) != '0;
    endfunction : misaligned

    ////////////////////////////////////////////////////////////////////////
    // combinational datapath
    // note: the whole result settles within one cycle; widening the
    // shifters or adding ops here lengthens the critical path directly

    logic [SPU_VEC_W-1:0]   resNext;    // computed result
    logic                   faultNext;  // alignment exception
    logic                   splitNext;  // line split indication
    logic [2*SPU_VEC_W-1:0] catVal;     // dst:src concatenation for align
    logic [SPU_ADDR_W-1:0]  lineOff;    // offset within cache line
    logic [SPU_ADDR_W-1:0]  accBytes;   // access size in bytes

    // one operation per cycle; the narrow form uses only the low 64 bits
    // every output is defaulted first so no latch can form on any path
    always_comb begin
        resNext   = '0;
        faultNext = 1'b0;
        splitNext = 1'b0;
        catVal    = '0;
        accBytes  = req.wide ? SPU_ADDR_W'(SPU_WIDE_AL) : SPU_ADDR_W'(SPU_NAR_AL);
        lineOff   = req.addr & SPU_ADDR_W'(SPU_LINE_B - 1);
        case (req.op)
            SPU_OP_PACK_DW_W: begin
                // dst-derived words low, src-derived words high
                // saturation happens per element before placement, so no
                // carry or sign can leak between neighbouring words
                if (req.wide) begin
                    for (int i = 0; i < 4; i++) begin
                        resNext[16*i +: 16]      = satDw(req.dst[32*i +: 32]);
                        resNext[64 + 16*i +: 16] = satDw(req.src[32*i +: 32]);
                    end
                end else begin
                    for (int i = 0; i < 2; i++) begin
                        resNext[16*i +: 16]      = satDw(req.dst[32*i +: 32]);
                        resNext[32 + 16*i +: 16] = satDw(req.src[32*i +: 32]);
                    end
                end
            end
            SPU_OP_PACK_W_UB: begin
                // same placement as the dword pack, with byte elements
                // negative words floor at zero instead of wrapping
                if (req.wide) begin
                    for (int i = 0; i < 8; i++) begin
                        resNext[8*i +: 8]      = satWb(req.dst[16*i +: 16]);
                        resNext[64 + 8*i +: 8] = satWb(req.src[16*i +: 16]);
                    end
                end else begin
                    for (int i = 0; i < 4; i++) begin
                        resNext[8*i +: 8]      = satWb(req.dst[16*i +: 16]);
                        resNext[32 + 8*i +: 8] = satWb(req.src[16*i +: 16]);
                    end
                end
            end
            SPU_OP_UNPK_LO_W: begin
                // a zero src yields zero-extended dwords
                // the dst word always takes the lower half of each dword
                if (req.wide) begin
                    for (int i = 0; i < 4; i++) begin
                        resNext[32*i +: 16]      = req.dst[16*i +: 16];
                        resNext[32*i + 16 +: 16] = req.src[16*i +: 16];
                    end
                end else begin
                    for (int i = 0; i < 2; i++) begin
                        resNext[32*i +: 16]      = req.dst[16*i +: 16];
                        resNext[32*i + 16 +: 16] = req.src[16*i +: 16];
                    end
                end
            end
            SPU_OP_UNPK_HI_W: begin
                // same interleave as the low form, taken from the upper words
                if (req.wide) begin
                    for (int i = 0; i < 4; i++) begin
                        resNext[32*i +: 16]      = req.dst[64 + 16*i +: 16];
                        resNext[32*i + 16 +: 16] = req.src[64 + 16*i +: 16];
                    end
                end else begin
                    for (int i = 0; i < 2; i++) begin
                        resNext[32*i +: 16]      = req.dst[32 + 16*i +: 16];
                        resNext[32*i + 16 +: 16] = req.src[32 + 16*i +: 16];
                    end
                end
            end
            SPU_OP_SRA_DW: begin
                // counts of 32 or more saturate to all sign bits
                // clamping the count keeps the shifter small and matches
                // the arithmetic meaning of an oversized shift
                for (int i = 0; i < 4; i++) begin
                    if (req.wide || i < 2) begin
                        resNext[32*i +: 32] = $signed(req.dst[32*i +: 32]) >>>
                            ((req.shamt > SPU_SRA_MAX) ? SPU_SRA_MAX
                                                       : req.shamt);
                    end
                end
            end
            SPU_OP_ALIGN_B: begin
                // narrow form concatenates only the low 64-bit halves
                // an immediate past the concatenation width shifts in zeros
                // wide form keeps the low 128 bits of the 256-bit concatenation
                if (req.wide) begin
                    catVal  = {req.dst, req.src} >> {req.imm, 3'b000};
                    resNext = catVal[SPU_VEC_W-1:0];
                end else begin
                    catVal  = {128'h0, req.dst[SPU_NAR_W-1:0], req.src[SPU_NAR_W-1:0]}
                              >> {req.imm, 3'b000};
                    resNext = {64'h0, catVal[SPU_NAR_W-1:0]};
                end
            end
            SPU_OP_LOAD, SPU_OP_LOAD_U: begin
                // alignment check; the data path itself lies outside this unit
                // fault wins over split: a faulting access never reaches memory
                if (req.wide) begin
                    faultNext = (req.op == SPU_OP_LOAD) &&
                                misaligned(req.addr, SPU_WIDE_AL);
                end else begin
                    faultNext = 1'b0;
                end
                splitNext = !faultNext &&
                            (lineOff + accBytes > SPU_ADDR_W'(SPU_LINE_B));
                // an 8-byte aligned narrow access can never straddle a line
                if (!req.wide && !misaligned(req.addr, SPU_NAR_AL)) begin
                    splitNext = 1'b0;
                end
            end
            default: begin
                // undecoded op: result is zero, still reported valid except for SPU_OP_NOP
                resNext = '0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // output register: one-cycle latency, result valid for one cycle
    // data is zeroed on idle cycles so a stale result never looks fresh
    // to a consumer that ignores the valid bit
    // fault and lineSplit are qualified by valid here, so a request that
    // is not taken can never raise an exception toward issue

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp <= '0;
        end else begin
            rsp.valid     <= req.valid && (req.op != SPU_OP_NOP);
            rsp.data      <= req.valid ? resNext : '0;
            rsp.fault     <= req.valid && faultNext;
            rsp.lineSplit <= req.valid && splitNext;
        end
    end

endmodule : spu_unit

// ==== spu_issue_model.sv ====
// issue-side model: presents decoded requests to the datapath
`timescale 1ns/1ns
module spu_issue_model
    import spu_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire spu_req_type cmd,
    output spu_req_type      req
);
    // launch on the falling edge so the datapath never sees a request mid-change
    always_ff @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req <= '0;    // nothing issued while the core is in reset
        end else begin
            req <= cmd;   // idle command is all zero, so stale operands never linger
        end
    end
endmodule : spu_issue_model

// ==== spu_unit_properties.sv ====
// checker: timing and result relations of the pack/unpack/align datapath
`timescale 1ns/1ns
module spu_unit_checker
    import spu_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire spu_req_type req,
    input wire spu_rsp_type rsp
);
    spu_req_type prevReq;   // request seen at the previous edge
    // one-edge history, so consequents can name the operands of the taken op
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) prevReq <= '0;
        else prevReq <= req;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////
    result_pulse_a: assert property (req.valid && req.op != SPU_OP_NOP |=> rsp.valid)
        else $error("no result one cycle after a taken op");
    no_spurious_a: assert property (!req.valid || req.op == SPU_OP_NOP |=> !rsp.valid)
        else $error("result without a taken op");
    align_fault_a: assert property (
        req.valid |=> rsp.fault == (prevReq.op == SPU_OP_LOAD
        && prevReq.wide && prevReq.addr[3:0] != 4'h0))
        else $error("alignment fault wrong");
    line_split_a: assert property (
        req.valid && req.op inside {SPU_OP_LOAD, SPU_OP_LOAD_U} |=>
        rsp.lineSplit == (!rsp.fault && ({1'b0, prevReq.addr[5:0]}
        + (prevReq.wide ? 7'h10 : 7'h08) > 7'h40)))
        else $error("line split flag wrong");
    load_data_a: assert property (req.valid && req.op inside {SPU_OP_LOAD, SPU_OP_LOAD_U}
        |=> rsp.data == '0) else $error("load result not zero");
    sra_sign_a: assert property (req.valid && req.op == SPU_OP_SRA_DW |=>
        rsp.data[31] == prevReq.dst[31] && rsp.data[63] == prevReq.dst[63])
        else $error("shift lost the sign");
    unpack_low_a: assert property (req.valid && req.op == SPU_OP_UNPK_LO_W |=>
        rsp.data[31:0] == {prevReq.src[15:0], prevReq.dst[15:0]})
        else $error("low unpack order wrong");
    unpack_high_a: assert property (
        req.valid && req.wide && req.op == SPU_OP_UNPK_HI_W |=>
        rsp.data[31:0] == {prevReq.src[79:64], prevReq.dst[79:64]})
        else $error("high unpack picked wrong words");
    narrow_upper_a: assert property (
        req.valid && !req.wide && req.op != SPU_OP_NOP |=>
        rsp.data[127:64] == 64'h0)
        else $error("narrow result upper half not zero");
    fault_seen_c: cover property (rsp.fault);
    split_seen_c: cover property (rsp.lineSplit);
    sra_seen_c: cover property (req.valid && req.op == SPU_OP_SRA_DW);
endmodule : spu_unit_checker
bind spu_unit spu_unit_checker u_checker (.clk(clk), .rst_n(rst_n), .req(req), .rsp(rsp));

// ==== spu_unit_tb.sv ====
// self-checking bench for the pack/unpack/align datapath
`timescale 1ns/1ns
module spu_unit_tb;
    import spu_pkg::*;
    logic        clk       = 1'b0;   // core clock
    logic        rst_n     = 1'b0;   // core reset, active low
    spu_req_type cmd       = '0;     // command handed to the issue model
    spu_req_type req;                // request as issued
    spu_rsp_type rsp;                // datapath result
    spu_req_type nxt;                // request being prepared
    int          nErrors   = 0;      // mismatches
    int          nCompared = 0;      // comparisons
    int          nCycles   = 0;      // cycles run
    always #5 clk = ~clk;
    // a hang is cut short well beyond the few dozen cycles the run needs
    always @(posedge clk) begin
        nCycles++;
        if (nCycles == 3000) begin
            nErrors++;
            printVerdict();
        end
    end
    spu_issue_model u_issue (.clk(clk), .rst_n(rst_n), .cmd(cmd), .req(req));
    spu_unit u_dut (.clk(clk), .rst_n(rst_n), .req(req), .rsp(rsp));
    ////////////////////////////////////////////////////////////////////////////
    task automatic printVerdict();
        if (nErrors == 0 && nCompared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : printVerdict
    task automatic setOp(input spu_op_type op, input logic wide);
        nxt       = '0;
        nxt.valid = 1'b1;
        nxt.op    = op;
        nxt.wide  = wide;
    endtask : setOp
    // one request, then the registered result is judged one cycle later
    task automatic issue(input logic [127:0] expD, input logic expF, input logic expS);
        @(posedge clk);
        cmd = nxt;
        @(negedge clk);
        @(posedge clk);
        cmd = '0;
        @(negedge clk);
        nCompared++;
        if (rsp.valid !== 1'b1 || rsp.data !== expD || rsp.fault !== expF
            || rsp.lineSplit !== expS) begin
            nErrors++;
            $display("unexpected at %0t: op %0d gave %h", $time, nxt.op, rsp.data);
        end
    endtask : issue
    // saturation both ways, negative words that an unsigned reading would pass
    task automatic packTest();
        setOp(SPU_OP_PACK_DW_W, 1'b1);
        nxt.dst = 128'hFFFFFFFB_00000005_FFFF0000_00012345;
        nxt.src = 128'h00012345_FFFF0000_00000005_FFFFFFFB;
        issue(128'h7FFF8000_0005FFFB_FFFB0005_80007FFF, 1'b0, 1'b0);
        nxt.wide = 1'b0;
        issue(128'h0005FFFB_80007FFF, 1'b0, 1'b0);
        setOp(SPU_OP_PACK_W_UB, 1'b1);
        nxt.dst = {2{64'h00FF_007F_FF80_0100}};
        nxt.src = {2{64'h8000_7FFF_0000_0001}};
        issue({{2{32'h00FF0001}}, {2{32'hFF7F00FF}}}, 1'b0, 1'b0);
        nxt.wide = 1'b0;
        issue(128'h00FF0001_FF7F00FF, 1'b0, 1'b0);
    endtask : packTest
    // top bits set in every word, so a sign leak into the upper half shows
    task automatic unpackTest();
        setOp(SPU_OP_UNPK_LO_W, 1'b1);
        nxt.dst = 128'h8007_8006_8005_8004_8003_8002_8001_8000;
        issue(128'h0000_8003_0000_8002_0000_8001_0000_8000, 1'b0, 1'b0);
        nxt.op = SPU_OP_UNPK_HI_W;
        issue(128'h0000_8007_0000_8006_0000_8005_0000_8004, 1'b0, 1'b0);
        nxt.op  = SPU_OP_UNPK_LO_W;
        nxt.src = 128'hA007_A006_A005_A004_A003_A002_A001_A000;
        issue(128'hA003_8003_A002_8002_A001_8001_A000_8000, 1'b0, 1'b0);
    endtask : unpackTest
    task automatic shiftAlignTest();
        setOp(SPU_OP_SRA_DW, 1'b1);
        nxt.dst   = 128'h8000_0000_7FFF_FFFF_F000_0000_0000_1230;
        nxt.shamt = 6'h04;
        issue(128'hF800_0000_07FF_FFFF_FF00_0000_0000_0123, 1'b0, 1'b0);
        nxt.shamt = 6'h28;
        issue(128'hFFFF_FFFF_0000_0000_FFFF_FFFF_0000_0000, 1'b0, 1'b0);
        setOp(SPU_OP_ALIGN_B, 1'b1);
        nxt.dst = 128'h1F1E1D1C_1B1A1918_17161514_13121110;
        nxt.src = 128'h0F0E0D0C_0B0A0908_07060504_03020100;
        nxt.imm = 5'h03;
        issue(128'h1211100F_0E0D0C0B_0A090807_06050403, 1'b0, 1'b0);
    endtask : shiftAlignTest
    task automatic loadCase(input spu_op_type op, input logic wide, input logic [7:0] a,
                            input logic f, input logic s);
        setOp(op, wide);
        nxt.addr = {56'h10, a};
        issue('0, f, s);
    endtask : loadCase
    // boundaries just inside and just across a line
    task automatic loadTest();
        loadCase(SPU_OP_LOAD,   1'b1, 8'h08, 1'b1, 1'b0);
        loadCase(SPU_OP_LOAD_U, 1'b1, 8'h08, 1'b0, 1'b0);
        loadCase(SPU_OP_LOAD,   1'b1, 8'h30, 1'b0, 1'b0);
        loadCase(SPU_OP_LOAD,   1'b0, 8'h3C, 1'b0, 1'b1);
        loadCase(SPU_OP_LOAD,   1'b0, 8'h38, 1'b0, 1'b0);
    endtask : loadTest
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        packTest();
        unpackTest();
        shiftAlignTest();
        loadTest();
        printVerdict();
    end
endmodule : spu_unit_tb
